/* File: rlr_step.sv */
// raise/lower ramp level: shared package and the per-cycle step/clamp stage
// assumes one clock domain; limits and preset are signed hundredths of a percent
`timescale 1ns/1ps

package rlr_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RATE = 8'h04;
  localparam logic [7:0] OFF_MAX = 8'h08;
  localparam logic [7:0] OFF_MIN = 8'h0c;
  localparam logic [7:0] OFF_PRESET = 8'h10;
  localparam logic [7:0] OFF_LEVEL = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // control and status field positions
  localparam int CTRL_RAISE_BIT = 0;
  localparam int CTRL_LOWER_BIT = 1;
  localparam int CTRL_PRESET_BIT = 2;
  localparam int STAT_UP_BIT = 0;
  localparam int STAT_DOWN_BIT = 1;
  localparam int STAT_AT_MAX_BIT = 2;
  localparam int STAT_AT_MIN_BIT = 3;
  // reset values: 10.0 s, +100.00 %, -100.00 %, 0.00 %
  localparam logic [12:0] RATE_RST = 13'h0064;
  localparam logic signed [15:0] MAX_RST = 16'sh2710;
  localparam logic signed [15:0] MIN_RST = -16'sh2710;
  localparam logic signed [15:0] PRESET_RST = 16'sh0000;
  // ramp time limit 600.0 s in 0.1 s units
  localparam logic [12:0] RATE_LIMIT = 13'h1770;
  // timing: 100.00 % is 10000 hundredths, rate counted in 100 ms units
  localparam int CLK_PERIOD_NS = 50;
  localparam int RATE_UNIT_NS = 100_000_000;
  localparam int FULL_SCALE = 10000;
  localparam int CYC_PER_RATE_UNIT = RATE_UNIT_NS / CLK_PERIOD_NS;
  localparam int CYC_PER_STEP_PER_UNIT = CYC_PER_RATE_UNIT / FULL_SCALE;

  typedef enum logic [0:0] {ST_RESTORE, ST_RUN} rlr_state_t;

  // whole state of the top module
  typedef struct packed {
    rlr_state_t st;
    logic signed [15:0] level;
    logic [20:0] cnt;
    logic [2:0] ctrl;
    logic [12:0] rate;
    logic signed [15:0] hi;
    logic signed [15:0] lo;
    logic signed [15:0] pre;
    logic [31:0] prdata;
  } rlr_regs_t;
endpackage

module rlr_step (
  input wire logic signed [15:0] level_i,
  input wire logic signed [15:0] hi_i,
  input wire logic signed [15:0] lo_i,
  input wire logic signed [15:0] pre_i,
  input wire logic preset_i,
  input wire logic raise_i,
  input wire logic lower_i,
  input wire logic step_i,
  input wire logic jump_i,
  output logic signed [15:0] level_o,
  output logic moving_o,
  output logic up_o
);
  logic signed [15:0] goal;

  // pick the goal, then move one hundredth toward it (never past it), or straight to it on preset or jump
  always_comb begin
    goal = level_i;
    if (preset_i) begin
      goal = pre_i;
    end else if (raise_i && !lower_i) begin
      goal = hi_i;
    end else if (lower_i && !raise_i) begin
      goal = lo_i;
    end else if (level_i > hi_i) begin
      goal = hi_i;
    end else if (level_i < lo_i) begin
      goal = lo_i;
    end
    moving_o = !preset_i && (goal != level_i);
    up_o = goal > level_i;
    level_o = level_i;
    if (preset_i || jump_i) begin
      level_o = goal;
    end else if (step_i && moving_o) begin
      level_o = up_o ? level_i + 16'sd1 : level_i - 16'sd1;
    end
  end
endmodule // rlr_step

/* File: rlr_top.sv */
// raise/lower ramp level: apb register file, ramp timer and retained level
// assumes raise/lower/preset come from logic on clk_i; nv_level_i is a stable
// backup copy of the level, read once after reset release
//
// Contract
// - preset input forces level to preset value
// - raise alone ramps up, stops at maximum
// - lower alone ramps down, stops at minimum
// - hold; above maximum ramps down to maximum
// - hold; below minimum ramps up to minimum
// - one rate: time for full span, up to 600s
// - level kept over power loss and restored
`timescale 1ns/1ps

module rlr_top #(
  parameter int CYC_PER_STEP = rlr_pkg::CYC_PER_STEP_PER_UNIT
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic raise_i,
  input wire logic lower_i,
  input wire logic preset_i,
  input wire logic signed [15:0] nv_level_i,
  output logic signed [15:0] nv_level_o,
  output logic signed [15:0] level_o
);
  rlr_pkg::rlr_regs_t r;
  rlr_pkg::rlr_regs_t n;
  logic signed [15:0] step_level;
  logic moving;
  logic up;
  logic step_en;
  logic [20:0] period;
  logic eff_raise;
  logic eff_lower;
  logic eff_preset;
  logic [3:0] status;
  logic [31:0] rd_mux;
  logic wr_acc;
  logic [15:0] wr_rate;

  // decode an offset into a register slot, 0 means unmapped
  function automatic logic [2:0] reg_slot(input logic [7:0] a);
    if (a == rlr_pkg::OFF_CTRL) begin
      reg_slot = 3'h1;
    end else if (a == rlr_pkg::OFF_RATE) begin
      reg_slot = 3'h2;
    end else if (a == rlr_pkg::OFF_MAX) begin
      reg_slot = 3'h3;
    end else if (a == rlr_pkg::OFF_MIN) begin
      reg_slot = 3'h4;
    end else if (a == rlr_pkg::OFF_PRESET) begin
      reg_slot = 3'h5;
    end else if (a == rlr_pkg::OFF_LEVEL) begin
      reg_slot = 3'h6;
    end else if (a == rlr_pkg::OFF_STATUS) begin
      reg_slot = 3'h7;
    end else begin
      reg_slot = 3'h0;
    end
  endfunction

  // requests from sequencer pins or software control bits
  assign eff_raise = raise_i | r.ctrl[rlr_pkg::CTRL_RAISE_BIT];
  assign eff_lower = lower_i | r.ctrl[rlr_pkg::CTRL_LOWER_BIT];
  assign eff_preset = preset_i | r.ctrl[rlr_pkg::CTRL_PRESET_BIT];

  // cycles per hundredth: rate (0.1 s units) times CYC_PER_STEP, cycles per hundredth per unit
  assign period = 21'(r.rate * 21'(CYC_PER_STEP));
  assign step_en = moving && (r.cnt >= period - 21'd1);

  rlr_step u_step (
    .level_i(r.level),
    .hi_i(r.hi),
    .lo_i(r.lo),
    .pre_i(r.pre),
    .preset_i(eff_preset),
    .raise_i(eff_raise),
    .lower_i(eff_lower),
    .step_i(step_en),
    .jump_i(r.rate == 13'h0000),
    .level_o(step_level),
    .moving_o(moving),
    .up_o(up)
  );

  // status bits show the ramp's own state
  always_comb begin
    status = 4'h0;
    status[rlr_pkg::STAT_UP_BIT] = moving && up;
    status[rlr_pkg::STAT_DOWN_BIT] = moving && !up;
    status[rlr_pkg::STAT_AT_MAX_BIT] = r.level == r.hi;
    status[rlr_pkg::STAT_AT_MIN_BIT] = r.level == r.lo;
  end

  // read data multiplexer, narrow fields zero-extended
  always_comb begin
    case (reg_slot(paddr_i))
      3'h1: rd_mux = {29'h0, r.ctrl};
      3'h2: rd_mux = {19'h0, r.rate};
      3'h3: rd_mux = {16'h0, r.hi};
      3'h4: rd_mux = {16'h0, r.lo};
      3'h5: rd_mux = {16'h0, r.pre};
      3'h6: rd_mux = {16'h0, r.level};
      3'h7: rd_mux = {28'h0, status};
      default: rd_mux = 32'h0;
    endcase
  end

  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign wr_rate = pwdata_i[15:0];

  // next state: level restore, ramp timer, register writes, read capture
  always_comb begin
    n = r;
    case (r.st)
      rlr_pkg::ST_RESTORE: begin
        n.level = nv_level_i;
        n.cnt = 21'h0;
        n.st = rlr_pkg::ST_RUN;
      end
      default: begin
        n.level = step_level;
        if (!moving || step_en) begin
          n.cnt = 21'h0;
        end else begin
          n.cnt = r.cnt + 21'd1;
        end
      end
    endcase
    if (wr_acc) begin
      if (reg_slot(paddr_i) == 3'h1) begin
        n.ctrl = pwdata_i[2:0];
      end else if (reg_slot(paddr_i) == 3'h2) begin
        // saturate at the 600.0 s ceiling
        n.rate = (wr_rate > 16'(rlr_pkg::RATE_LIMIT)) ? rlr_pkg::RATE_LIMIT : wr_rate[12:0];
      end else if (reg_slot(paddr_i) == 3'h3) begin
        n.hi = pwdata_i[15:0];
      end else if (reg_slot(paddr_i) == 3'h4) begin
        n.lo = pwdata_i[15:0];
      end else if (reg_slot(paddr_i) == 3'h5) begin
        n.pre = pwdata_i[15:0];
      end
    end
    if (psel_i && !penable_i && !pwrite_i) begin
      n.prdata = rd_mux; // captured in setup, shown in access
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r.st <= rlr_pkg::ST_RESTORE;
      r.level <= 16'sh0000;
      r.cnt <= 21'h0;
      r.ctrl <= 3'h0;
      r.rate <= rlr_pkg::RATE_RST;
      r.hi <= rlr_pkg::MAX_RST;
      r.lo <= rlr_pkg::MIN_RST;
      r.pre <= rlr_pkg::PRESET_RST;
      r.prdata <= 32'h0;
    end else begin
      r <= n;
    end
  end

  // zero-wait apb answer, error on unmapped offsets
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && (reg_slot(paddr_i) == 3'h0);
  assign prdata_o = r.prdata;
  // level mirrored out for the backup store
  assign nv_level_o = r.level;
  assign level_o = r.level;
endmodule // rlr_top

/* File: rlr_nv_model.sv */
// backup store for the ramp level, standing outside the ramp block
// assumes the block mirrors its level on nv_level_o every clock
`timescale 1ns/1ps
module rlr_nv_model (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic signed [15:0] level_i,
  output logic signed [15:0] level_o
);
  // keep last level while the block is powered, hold it through reset
  initial level_o = 16'sh012c;
  always @(posedge clk_i) if (en_i) level_o <= level_i;
endmodule // rlr_nv_model

/* File: rlr_top_props.sv */
// checker for the ramp level block, watching its top ports only
// assumes one clock, reset async active low
`timescale 1ns/1ps
module rlr_top_props #(parameter int CYC_PER_STEP = 1) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic raise_i,
  input wire logic lower_i,
  input wire logic preset_i,
  input wire logic signed [15:0] nv_level_i,
  input wire logic signed [15:0] nv_level_o,
  input wire logic signed [15:0] level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // bus answer, error flag, read data, backup mirror, restore and preset hold
  chk_ready_high: assert property (pready_o) else $error("pready low");
  chk_err_unmapped: assert property (psel_i && penable_i && paddr_i > 8'h18 |-> pslverr_o)
    else $error("no error on unmapped");
  chk_err_mapped: assert property (psel_i && penable_i && paddr_i <= 8'h18 && paddr_i[1:0] == 2'b00 |-> !pslverr_o)
    else $error("error on mapped");
  chk_err_idle: assert property (!penable_i |-> !pslverr_o) else $error("error outside access");
  chk_rdata_hold: assert property (!(psel_i && !penable_i) |=> $stable(prdata_o)) else $error("read data moved");
  chk_level_read: assert property (psel_i && !penable_i && !pwrite_i && paddr_i == 8'h14
    |=> prdata_o == {16'h0000, $past(level_o)}) else $error("level read wrong");
  chk_nv_mirror: assert property (nv_level_o == level_o) else $error("backup copy differs");
  chk_restore_level: assert property ($rose(rst_b_i) |=> level_o == $past(nv_level_i))
    else $error("level not restored");
  chk_preset_stable: assert property (preset_i && $past(preset_i) && !$past(psel_i && penable_i && pwrite_i)
    && $past(rst_b_i, 2) |=> $stable(level_o)) else $error("level moved under preset");
  // main scenarios
  cov_raise: cover property (raise_i && !preset_i ##1 level_o > $past(level_o));
  cov_lower: cover property (lower_i && !preset_i ##1 level_o < $past(level_o));
  cov_preset: cover property (preset_i [*2]);
endmodule // rlr_top_props
bind rlr_top rlr_top_props #(.CYC_PER_STEP(CYC_PER_STEP)) i_rlr_top_props (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .raise_i(raise_i), .lower_i(lower_i),
  .preset_i(preset_i), .nv_level_i(nv_level_i), .nv_level_o(nv_level_o), .level_o(level_o));

/* File: rlr_top_tb_top.sv */
// self-checking bench for the ramp level block with its backup store
// assumes step period of CYC_PER_STEP=1 times the rate value
`timescale 1ns/1ps
module rlr_top_tb_top;
  logic clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err, raise_i, lower_i, preset_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, lf;
  logic signed [15:0] nv_in, nv_out, level_o, m;
  logic [31:0] rv [4] = '{32'h64, 32'h2710, 32'hd8f0, 32'h0};
  int fail_count, tests_run;
  rlr_top #(.CYC_PER_STEP(1)) i_rlr_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .raise_i(raise_i), .lower_i(lower_i), .preset_i(preset_i),
    .nv_level_i(nv_in), .nv_level_o(nv_out), .level_o(level_o));
  rlr_nv_model i_rlr_nv_model (.clk_i(clk_i), .en_i(rst_b_i), .level_i(nv_out), .level_o(nv_in));
  // clock
  initial begin
    clk_i = 0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one apb transfer, setup then access until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    // access phase: hold the request until pready is seen high at an edge
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) begin
      fail_count++;
      results();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  // main sequence
  initial begin
    {psel_i, penable_i, pwrite_i, raise_i, lower_i, preset_i, rst_b_i} = '0;
    {paddr_i, pwdata_i} = '0;
    fail_count = 0;
    tests_run = 0;
    lf = nxt(32'h8150732e);
    m = 16'(lf[9:0]);
    cyc(2);
    rst_b_i <= 1;
    cyc(3);
    chk("restore", level_o, 32'sd300);
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'(4 + 4 * i), 0);
      chk("reset value", rd, rv[i]);
    end
    apb(0, 8'h1c, 32'hffffffff);
    chk("unmapped error", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("registers done");
    apb(1, rlr_pkg::OFF_RATE, 0);
    apb(1, rlr_pkg::OFF_MAX, 32'(m));
    raise_i <= 1;
    cyc(2);
    chk("jump up", level_o, 32'(m));
    apb(1, rlr_pkg::OFF_MIN, 32'(-m));
    raise_i <= 0;
    lower_i <= 1;
    cyc(2);
    chk("jump down", level_o, 32'(-m));
    lower_i <= 0;
    apb(1, rlr_pkg::OFF_RATE, 3);
    apb(1, rlr_pkg::OFF_MAX, 32'(-m + 5));
    raise_i <= 1;
    cyc(8);
    chk("ramping", level_o, 32'(-m + 2));
    cyc(14);
    chk("top stop", level_o, 32'(-m + 5));
    raise_i <= lf[3];
    lower_i <= lf[3];
    apb(1, rlr_pkg::OFF_MAX, 32'(-m + 2));
    cyc(14);
    chk("down to max", level_o, 32'(-m + 2));
    apb(1, rlr_pkg::OFF_MAX, 32'(-m + 8));
    apb(1, rlr_pkg::OFF_MIN, 32'(-m + 6));
    cyc(16);
    chk("up to min", level_o, 32'(-m + 6));
    // software raise through the control register, pins idle
    raise_i <= 0;
    lower_i <= 0;
    apb(1, rlr_pkg::OFF_CTRL, 32'(1 << rlr_pkg::CTRL_RAISE_BIT));
    cyc(8);
    apb(0, rlr_pkg::OFF_STATUS, 0);
    chk("status at max", rd, 32'(1 << rlr_pkg::STAT_AT_MAX_BIT));
    chk("soft raise", level_o, 32'(-m + 8));
    apb(1, rlr_pkg::OFF_CTRL, 0);
    $display("ramps done");
    apb(1, rlr_pkg::OFF_RATE, 32'h1b58);
    apb(0, rlr_pkg::OFF_RATE, 0);
    chk("rate limit", rd, 32'h1770);
    apb(1, rlr_pkg::OFF_PRESET, 32'(-m));
    preset_i <= 1;
    raise_i <= 1;
    lower_i <= 0;
    cyc(3);
    chk("preset", level_o, 32'(-m));
    {preset_i, raise_i} <= 2'b00;
    rst_b_i <= 0;
    cyc(2);
    rst_b_i <= 1;
    cyc(3);
    chk("restore again", level_o, 32'(-m));
    $display("reset done");
    results();
  end
endmodule // rlr_top_tb_top
